// File: rtl/ctimer_pkg.sv
// constants and types for the compact timer with compare and pwm
package ctimer_pkg;
  localparam logic [2:0] ADDR_CTRL0 = 3'h0;
  localparam logic [2:0] ADDR_CTRL1 = 3'h1;
  localparam logic [2:0] ADDR_CNT_LO = 3'h2;
  localparam logic [2:0] ADDR_CNT_HI = 3'h3;
  localparam logic [2:0] ADDR_CMPA_LO = 3'h4;
  localparam logic [2:0] ADDR_CMPA_HI = 3'h5;
  localparam logic [2:0] ADDR_PERIOD = 3'h6;
  localparam logic [2:0] ADDR_FLAGS = 3'h7;
  // control register zero fields
  localparam int CTRL0_PAUSE = 7;
  localparam int CTRL0_CKSEL_LSB = 4;
  localparam int CTRL0_ENABLE = 3;
  localparam logic [7:0] CTRL0_MASK = 8'hf8;
  // control register one fields
  localparam int CTRL1_MODE_LSB = 6;
  localparam int CTRL1_ACT_LSB = 4;
  localparam int CTRL1_OCTL = 3;
  localparam int CTRL1_POL = 2;
  localparam int CTRL1_DPX = 1;
  localparam int CTRL1_CCLR = 0;
  // flag register fields, write one to clear
  localparam int FLAG_A = 0;
  localparam int FLAG_P = 1;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [7:0] PERIOD_ZERO = 8'h00;
  localparam logic [15:0] CMPA_ZERO = 16'h0000;
  localparam logic [16:0] FULL_SPAN = 17'h10000;
  localparam logic [2:0] DIV4_LAST = 3'h3;
  localparam logic [2:0] DIV16_LAST = 3'h7;
  localparam logic [6:0] DIV64_LAST = 7'h3f;
  localparam logic [3:0] DIV16_FULL = 4'hf;

  typedef enum logic [1:0] {
    MODE_COMPARE = 2'b00,
    MODE_UNDEF = 2'b01,
    MODE_PWM = 2'b10,
    MODE_TIMER = 2'b11
  } mode_type;

  typedef enum logic [1:0] {
    ACT_NONE = 2'b00,
    ACT_LOW = 2'b01,
    ACT_HIGH = 2'b10,
    ACT_TOGGLE = 2'b11
  } action_type;

  typedef enum logic [2:0] {
    CK_SYS_DIV4 = 3'b000,
    CK_SYS = 3'b001,
    CK_H_DIV16 = 3'b010,
    CK_H_DIV64 = 3'b011,
    CK_SUB_A = 3'b100,
    CK_SUB_B = 3'b101,
    CK_PIN_RISE = 3'b110,
    CK_PIN_FALL = 3'b111
  } clk_sel_type;
endpackage

// File: rtl/compact_timer.sv
// compact 16-bit timer with two comparators, compare output and pwm
//
// Overview of operation
// - counter readable as low and high bytes, read only, zero after reset
// - compare-a value in two read/write bytes, compared to all 16 bits
// - 8-bit period byte, read/write, compared to counter bits 15..8
// - clear-select zero: period match clears the counter
// - period zero lets the counter wrap by overflow
// - mode field 00 compare, 11 timer, 10 pwm
// - compare/timer, clear-select zero: clear on p match/overflow, both flags
// - clear-select one: a match clears counter, only flag a raised
// - clear-select one, compare-a zero: wrap at ffff, no flag a
// - compare mode: pin changes only on a-match, never on p-match
// - compare mode action: high, low, toggle, or no change when zero
// - enable rising edge loads pin with initial level from output control; in pwm it loads the inactive level
// - timer mode behaves as compare mode but leaves pin undriven
// - pwm ignores clear-select, duty/period select picks period register
// - dpx zero: period is 256*period value, duty is compare-a
// - dpx one: period is compare-a, duty is 256*period value
// - pwm raises flag a on a-match, flag p on period match
// - duty at or above period gives constant active output
// - polarity inverts final pwm; output control picks active level
// - forced inactive/active action keeps pwm counting and flags running
// - enable rising clears counter; falling stops and holds count
// - compare action 01 low, 10 high, 11 toggle, 00 unchanged
// - pwm action 00 inactive, 01 active, 10 pwm, 11 undefined
// - output control one active high in pwm; initial level in compare
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module compact_timer
  import ctimer_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [2:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic ext_clk_in,
  input wire logic sub_tick_in,
  output logic [7:0] rdata_out,
  output logic pin_out,
  output logic pin_oe_out,
  output logic match_a_out,
  output logic match_p_out
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [15:0] count;
    logic [15:0] cmpa;
    logic [7:0] period;
    logic flag_a;
    logic flag_p;
    logic pin;
    logic pin_oe;
    logic en_d;
    logic [6:0] div;
    logic ext_d;
    logic [7:0] rdata;
  } state_type;

  state_type s_reg;
  state_type s_next;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] read_mux(input state_type s,
                                          input logic [2:0] a);
    logic [7:0] v;
    v = RESET_BYTE;
    if (a == ADDR_CTRL0) begin
      v = s.ctrl0 & CTRL0_MASK;
    end else if (a == ADDR_CTRL1) begin
      v = s.ctrl1;
    end else if (a == ADDR_CNT_LO) begin
      v = s.count[7:0];
    end else if (a == ADDR_CNT_HI) begin
      v = s.count[15:8];
    end else if (a == ADDR_CMPA_LO) begin
      v = s.cmpa[7:0];
    end else if (a == ADDR_CMPA_HI) begin
      v = s.cmpa[15:8];
    end else if (a == ADDR_PERIOD) begin
      v = s.period;
    end else if (a == ADDR_FLAGS) begin
      v = {6'h00, s.flag_p, s.flag_a};
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic tick;
  logic en_rise;
  logic ovf;
  logic hit_a;
  logic hit_p;
  logic clr;
  logic set_a;
  logic set_p;
  logic pwm_raw;
  logic pwm_lvl;
  logic [16:0] span_p;
  logic [16:0] duty;
  logic [16:0] per;
  mode_type mode;
  action_type act;
  clk_sel_type cksel;

  always_comb begin
    s_next = s_reg;
    mode = mode_type'(s_reg.ctrl1[CTRL1_MODE_LSB +: 2]);
    act = action_type'(s_reg.ctrl1[CTRL1_ACT_LSB +: 2]);
    cksel = clk_sel_type'(s_reg.ctrl0[CTRL0_CKSEL_LSB +: 3]);
    en_rise = s_reg.ctrl0[CTRL0_ENABLE] & ~s_reg.en_d;
    s_next.en_d = s_reg.ctrl0[CTRL0_ENABLE];
    // prescaler runs freely so rates stay even across enable toggles
    s_next.div = s_reg.div + 7'h01;
    s_next.ext_d = ext_clk_in;
    case (cksel)
      CK_SYS_DIV4: tick = (s_reg.div[1:0] == DIV4_LAST[1:0]);
      CK_SYS: tick = 1'b1;
      CK_H_DIV16: tick = (s_reg.div[3:0] == DIV16_FULL);
      CK_H_DIV64: tick = (s_reg.div[5:0] == DIV64_LAST[5:0]);
      CK_PIN_RISE: tick = ext_clk_in & ~s_reg.ext_d;
      CK_PIN_FALL: tick = ~ext_clk_in & s_reg.ext_d;
      default: tick = sub_tick_in;
    endcase
    tick = tick & s_reg.ctrl0[CTRL0_ENABLE] & ~s_reg.ctrl0[CTRL0_PAUSE];

    // comparators
    hit_a = (s_reg.cmpa != CMPA_ZERO) && (s_reg.count == s_reg.cmpa);
    span_p = (s_reg.period == PERIOD_ZERO) ? FULL_SPAN :
             {1'b0, s_reg.period, 8'h00};
    // p match fires on the last clock of its 256*n span
    hit_p = ({1'b0, s_reg.count} + 17'h00001) == span_p;
    ovf = (s_reg.count == COUNT_MAX);
    set_a = 1'b0;
    set_p = 1'b0;
    clr = 1'b0;
    if (mode == MODE_PWM) begin
      set_a = hit_a;
      set_p = hit_p;
      if (s_reg.ctrl1[CTRL1_DPX]) begin
        clr = hit_a | ovf;
      end else begin
        clr = hit_p;
      end
    end else if (s_reg.ctrl1[CTRL1_CCLR]) begin
      set_a = hit_a;
      clr = hit_a | ovf;
    end else begin
      set_a = hit_a;
      set_p = hit_p;
      clr = hit_p;
    end

    // counter
    if (en_rise) begin
      s_next.count = CMPA_ZERO;
    end else if (tick) begin
      s_next.count = clr ? CMPA_ZERO : s_reg.count + COUNT_ONE;
    end

    // duty and period for pwm, 17 bits so 65536 fits
    if (s_reg.ctrl1[CTRL1_DPX]) begin
      per = {1'b0, s_reg.cmpa};
      duty = span_p;
    end else begin
      per = span_p;
      duty = {1'b0, s_reg.cmpa};
    end
    pwm_raw = (duty >= per) || ({1'b0, s_reg.count} < duty);
    pwm_lvl = pwm_raw ~^ s_reg.ctrl1[CTRL1_OCTL];
    pwm_lvl = pwm_lvl ^ s_reg.ctrl1[CTRL1_POL];

    // output pin
    s_next.pin_oe = (mode == MODE_COMPARE) || (mode == MODE_PWM);
    if (en_rise) begin
      s_next.pin = s_reg.ctrl1[CTRL1_OCTL];
      if (mode == MODE_PWM) begin
        s_next.pin = ~s_reg.ctrl1[CTRL1_OCTL] ^ s_reg.ctrl1[CTRL1_POL];
      end
    end else if (mode == MODE_COMPARE) begin
      if (tick && set_a) begin
        case (act)
          ACT_LOW: s_next.pin = 1'b0;
          ACT_HIGH: s_next.pin = 1'b1;
          ACT_TOGGLE: s_next.pin = ~s_reg.pin;
          default: s_next.pin = s_reg.pin;
        endcase
      end
    end else if (mode == MODE_PWM) begin
      case (act)
        ACT_NONE: s_next.pin = ~s_reg.ctrl1[CTRL1_OCTL] ^
                               s_reg.ctrl1[CTRL1_POL];
        ACT_LOW: s_next.pin = s_reg.ctrl1[CTRL1_OCTL] ^
                              s_reg.ctrl1[CTRL1_POL];
        ACT_HIGH: s_next.pin = pwm_lvl;
        default: s_next.pin = s_reg.pin;
      endcase
    end

    // register bus and sticky flags
    s_next.rdata = rd_in ? read_mux(s_reg, addr_in) : RESET_BYTE;
    if (wr_in) begin
      if (addr_in == ADDR_CTRL0) begin
        s_next.ctrl0 = wdata_in & CTRL0_MASK;
      end else if (addr_in == ADDR_CTRL1) begin
        s_next.ctrl1 = wdata_in;
      end else if (addr_in == ADDR_CMPA_LO) begin
        s_next.cmpa[7:0] = wdata_in;
      end else if (addr_in == ADDR_CMPA_HI) begin
        s_next.cmpa[15:8] = wdata_in;
      end else if (addr_in == ADDR_PERIOD) begin
        s_next.period = wdata_in;
      end else if (addr_in == ADDR_FLAGS) begin
        if (wdata_in[FLAG_A]) begin
          s_next.flag_a = 1'b0;
        end
        if (wdata_in[FLAG_P]) begin
          s_next.flag_p = 1'b0;
        end
      end
    end
    // set beats a clear in the same cycle
    if (tick && set_a && mode != MODE_UNDEF) begin
      s_next.flag_a = 1'b1;
    end
    if (tick && set_p && mode != MODE_UNDEF) begin
      s_next.flag_p = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata_out = s_reg.rdata;
  assign pin_out = s_reg.pin;
  assign pin_oe_out = s_reg.pin_oe;
  assign match_a_out = s_reg.flag_a;
  assign match_p_out = s_reg.flag_p;

endmodule
`default_nettype wire

// File: verification/compact_timer_asserts.sv
// checker for the compact timer register port, flags and pin enable
`timescale 1ns/10ps
`default_nettype none
module compact_timer_asserts
  import ctimer_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [2:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic pin_oe_out,
  input wire logic match_a_out,
  input wire logic match_p_out
);
  logic rv_reg;
  logic [2:0] ra_reg;
  logic [7:0] c1_reg;
  // settle window after reset or a control register one write; outputs are pipelined
  logic [1:0] cfg_reg;
  wire logic wf = wr_in && addr_in == ADDR_FLAGS;
  always_ff @(posedge sys_clk_in) begin
    rv_reg <= rd_in && !rst_in;
    ra_reg <= addr_in;
    if (rst_in) begin
      c1_reg <= 8'h00;
      cfg_reg <= 2'h3;
    end else if (wr_in && addr_in == ADDR_CTRL1) begin
      c1_reg <= wdata_in;
      cfg_reg <= 2'h3;
    end else if (cfg_reg != 2'h0) begin
      cfg_reg <= cfg_reg - 2'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  property p_rd_idle; !rv_reg |-> rdata_out == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("idle read data");
  property p_rd_flags; rv_reg && ra_reg == ADDR_FLAGS |->
    rdata_out == {6'h00, $past(match_p_out), $past(match_a_out)}; endproperty
  a_rd_flags: assert property (p_rd_flags) else $error("flag read");
  property p_rd_ctl; rv_reg && ra_reg == ADDR_CTRL1 |-> rdata_out == c1_reg;
  endproperty
  a_rd_ctl: assert property (p_rd_ctl) else $error("control readback");
  property p_stk_a; match_a_out && !(wf && wdata_in[FLAG_A]) |=> match_a_out;
  endproperty
  a_stk_a: assert property (p_stk_a) else $error("flag a dropped");
  property p_stk_p; match_p_out && !(wf && wdata_in[FLAG_P]) |=> match_p_out;
  endproperty
  a_stk_p: assert property (p_stk_p) else $error("flag p dropped");
  property p_oe_cause; $changed(pin_oe_out) |-> cfg_reg != 2'h0; endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("pin enable moved");
  property p_oe_mode; cfg_reg == 2'h0 |->
    pin_oe_out == !c1_reg[CTRL1_MODE_LSB]; endproperty
  a_oe_mode: assert property (p_oe_mode) else $error("pin enable mode");
  property p_no_p; cfg_reg == 2'h0 && c1_reg[CTRL1_CCLR] &&
    c1_reg[7:6] != MODE_PWM |-> !$rose(match_p_out); endproperty
  a_no_p: assert property (p_no_p) else $error("flag p with clear a");
endmodule
bind compact_timer compact_timer_asserts u_chk (.sys_clk_in, .rst_in,
  .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .pin_oe_out,
  .match_a_out, .match_p_out);
`default_nettype wire

// File: verification/tb.sv
// self-checking bench for the compact timer
`timescale 1ns/10ps
`default_nettype none
module tb
  import ctimer_pkg::*;
;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [2:0] addr_in = 3'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic rd_d = 1'b0;
  logic ext_clk = 1'b0;
  logic [7:0] rdata_out;
  logic pin_out, pin_oe_out, match_a_out, match_p_out;
  logic [7:0] exp_q[$];
  logic [15:0] seed = 16'hff8a;
  logic [15:0] hi;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  // sub tick unused; the external pin toggles every clock
  compact_timer dut (.sys_clk_in, .rst_in, .addr_in, .wdata_in, .wr_in,
    .rd_in, .ext_clk_in(ext_clk), .sub_tick_in(1'b0), .rdata_out, .pin_out,
    .pin_oe_out, .match_a_out, .match_p_out);
  initial forever #20 sys_clk_in = ~sys_clk_in;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  // counter is stopped while reconfiguring, so no match lands mid-setup
  task automatic setup(input logic [7:0] c1, input logic [15:0] ca,
      input logic [7:0] pr);
    wr(ADDR_CTRL0, 8'h10);
    wr(ADDR_CTRL1, c1);
    wr(ADDR_CMPA_LO, ca[7:0]);
    wr(ADDR_CMPA_HI, ca[15:8]);
    wr(ADDR_PERIOD, pr);
    wr(ADDR_FLAGS, 8'h03);
    wr(ADDR_CTRL0, 8'h18);
  endtask
  // a 256-cycle window holds one whole period, so phase does not matter
  task automatic pwm(input logic [7:0] c1, input logic [15:0] ca,
      input logic [15:0] eh, input logic [7:0] ef);
    setup(c1, ca, 8'h01);
    tick(8);
    hi = 16'h0000;
    repeat (256) begin
      @(posedge sys_clk_in);
      hi = hi + {15'h0000, pin_out};
    end
    chk(hi, eh);
    rd(ADDR_FLAGS, ef);
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk_in) begin
    rd_d <= rd_in;
    ext_clk <= ~ext_clk;
    cyc <= cyc + 1;
    if (rd_d) chk(rdata_out, exp_q.pop_front());
    if (cyc == 8000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    repeat (20) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    for (int a = 0; a < 8; a++) rd(3'(a), 8'h00);
    for (int a = 4; a < 7; a++) begin
      seed = lfsr(seed);
      wr(3'(a), seed[7:0]);
      rd(3'(a), seed[7:0]);
    end
    wr(ADDR_CNT_LO, 8'h5a);
    rd(ADDR_CNT_LO, 8'h00);
    $display("test registers done");
    for (int a = 0; a < 4; a++) begin
      setup({2'b00, 2'(a), a == 1, 3'h0}, 16'h0010, 8'h01);
      tick(4);
      chk(pin_out, a == 1);
      tick(40);
      chk(pin_out, a > 1);
      rd(ADDR_FLAGS, 8'h01);
    end
    tick(240);
    chk(pin_out, 1'b0);
    chk(pin_oe_out, 1'b1);
    rd(ADDR_FLAGS, 8'h03);
    rd(ADDR_CNT_HI, 8'h00);
    $display("test compare done");
    setup(8'hc1, 16'h0200, 8'h01);
    tick(600);
    chk(pin_oe_out, 1'b0);
    rd(ADDR_FLAGS, 8'h01);
    setup(8'hc1, 16'h0000, 8'h01);
    tick(300);
    rd(ADDR_FLAGS, 8'h00);
    rd(ADDR_CNT_HI, 8'h01);
    setup(8'hc0, 16'h0000, 8'h00);
    tick(300);
    rd(ADDR_CNT_HI, 8'h01);
    // divide-by-4 source, then the rising pin edge from a cleared count
    wr(ADDR_CTRL0, 8'h10);
    wr(ADDR_CTRL0, 8'h08);
    tick(1100);
    rd(ADDR_CNT_HI, 8'h01);
    wr(ADDR_CTRL0, 8'h10);
    wr(ADDR_CTRL0, 8'h68);
    tick(600);
    rd(ADDR_CNT_HI, 8'h01);
    $display("test timer done");
    pwm(8'ha8, 16'h0040, 16'd64, 8'h03);
    pwm(8'ha8, 16'h0100, 16'd256, 8'h02);
    pwm(8'hac, 16'h0100, 16'd0, 8'h02);
    pwm(8'ha0, 16'h0040, 16'd192, 8'h03);
    pwm(8'ha9, 16'h0040, 16'd64, 8'h03);
    pwm(8'haa, 16'h0080, 16'd256, 8'h01);
    pwm(8'h98, 16'h0040, 16'd256, 8'h03);
    pwm(8'h88, 16'h0040, 16'd0, 8'h03);
    $display("test pwm done");
    tick(3);
    results();
  end
endmodule
`default_nettype wire
